// file: one_wire_debug_link_pkg.sv
/*
 Constants and types shared by the one-wire debug data-link controller.
 Assumes a 10 MHz core clock and a byte-level receive/transmit layer outside.
*/
package one_wire_debug_link_pkg;
   localparam int CLOCK_PERIOD_NS = 100;
   // Access time-out, in its own unit
   localparam int ACCESS_TIMEOUT_NS = 100000;
   localparam int ACCESS_TIMEOUT_CYCLES = ACCESS_TIMEOUT_NS / CLOCK_PERIOD_NS;
   localparam logic [15:0] TIMEOUT_LIMIT = 16'(ACCESS_TIMEOUT_CYCLES);

   localparam logic [7:0] SYNC_CHARACTER = 8'h55;
   localparam logic [7:0] ACK_CHAR       = 8'h40;

   // Instruction byte layout
   localparam int OP_POS   = 5;
   localparam int SIZEA_POS = 2;
   localparam int SIZEB_POS = 0;
   localparam logic [2:0] OP_LOAD_DIRECT    = 3'h0;
   localparam logic [2:0] OP_LOAD_INDIRECT  = 3'h1;
   localparam logic [2:0] OP_STORE_DIRECT   = 3'h2;
   localparam logic [2:0] OP_STORE_INDIRECT = 3'h3;

   // Address-size field
   localparam logic [1:0] ASIZE_RESERVED = 2'h3;
   // Pointer field of the indirect instructions
   localparam logic [1:0] PTR_DEREF     = 2'h0;
   localparam logic [1:0] PTR_DEREF_INC = 2'h1;
   localparam logic [1:0] PTR_REGISTER  = 2'h2;

   // Error signature codes
   localparam logic [2:0] ERR_NONE       = 3'h0;
   localparam logic [2:0] ERR_PARITY     = 3'h1;
   localparam logic [2:0] ERR_FRAME      = 3'h2;
   localparam logic [2:0] ERR_TIMEOUT    = 3'h3;
   localparam logic [2:0] ERR_CONTENTION = 3'h4;

   localparam logic [31:0] PTR_RESET = 32'h0000_0000;

   typedef enum logic [3:0] {
      DISABLED, WAIT_SYNC, WAIT_INSTR, ADDR_IN, DATA_IN, BUS_ACCESS, TURN, TX_OUT, ERROR
   } mode_t;
endpackage

// file: one_wire_debug_link_ctrl.sv
/*
 Data-link controller of a one-wire half-duplex debug port: sync checking,
 disable, error state and recovery, guard time, direct and indirect loads,
 direct store and pointer store.
 Assumes a byte-level line layer that flags parity, frame, contention, break
 and sync measurement results, and a bus-access layer with a done pulse.
*/
// Overview of operation
// - Bad sync length disables the interface
// - Disable bit resets system, disables interface
// - Disable reset: CPU runs, clock request dropped
// - Line and time-out errors give signature codes
// - Any error enters the error state at once
// - Error state ignores everything except BREAK and the disable bit
// - Guard idle bits precede first response byte
// - Guard gap may stretch, never past time-out
// - Recommend two guard bits, one from programmer
// - Reach internal registers and system address space
// - Direct load: address bytes in, data out
// - Repeated direct load resends address, no increment
// - Load request handed to bus layer, data back
// - Direct store: address, ack, data, ack
// - Indirect load via pointer, optional post-increment
// - Indirect load data after guard time only
// - Sync character is eight bits, value 0x55
// - Address size: one, two, three bytes, reserved
module one_wire_debug_link_ctrl (
   input  wire logic                         clock,
   input  wire logic                         reset,
   input  wire logic                         sync_done,
   input  wire logic                         sync_overflow,
   input  wire logic                         sync_underflow,
   input  wire logic                         rx_valid,
   input  wire logic [7:0]                   rx_data,
   input  wire logic                         rx_parity_err,
   input  wire logic                         rx_frame_err,
   input  wire logic                         rx_break,
   input  wire logic                         tx_contention,
   input  wire logic                         bit_tick,
   output logic                              tx_valid,
   output logic [7:0]                        tx_data,
   input  wire logic                         tx_ready,
   input  wire logic [2:0]                   guard_time_field,
   input  wire logic                         iface_disable_bit,
   output logic [2:0]                        error_signature_field,
   output logic                              iface_enabled,
   output logic                              clk_request,
   output logic                              sys_reset,
   output logic                              cpu_run_req,
   output logic                              bus_req,
   output logic                              bus_write,
   output logic [31:0]                       bus_addr,
   output logic [31:0]                       bus_wdata,
   output logic [1:0]                        bus_size,
   input  wire logic                         bus_done,
   input  wire logic [31:0]                  bus_rdata,
   output logic [31:0]                       pointer
);
   import one_wire_debug_link_pkg::*;
   typedef struct packed {
      one_wire_debug_link_pkg::mode_t mode;
      logic [2:0]  op;
      logic [1:0]  size_a;
      logic [1:0]  size_b;
      logic [2:0]  cnt;
      logic [31:0] addr;
      logic [31:0] data;
      logic [31:0] ptr;
      logic [7:0]  guard_cnt;
      logic [15:0] timeout_cnt;
      logic [2:0]  err_sig;
      logic        sys_reset;
      logic        bus_req;
      logic        bus_write;
      logic        data_after_ack;
   } state_t;
   state_t st;
   state_t next_st;
   // Guard field 0..7 selects 128 down to 1 idle bits
   function automatic logic [7:0] guard_bits(input logic [2:0] field);
      guard_bits = 8'h80 >> field;
   endfunction
   function automatic logic [2:0] byte_count(input logic [1:0] size);
      byte_count = {1'b0, size} + 3'h1;
   endfunction
   function automatic logic [31:0] put_byte(input logic [31:0] word, input logic [2:0] idx,
                                            input logic [7:0] b);
      logic [31:0] mask;
      mask = 32'h0000_00FF << {idx[1:0], 3'b000};
      put_byte = (word & ~mask) | ({24'h000000, b} << {idx[1:0], 3'b000});
   endfunction

   always_comb begin
      next_st = st;
      next_st.sys_reset = 1'b0;
      if (st.guard_cnt != 8'h00 && bit_tick) begin
         next_st.guard_cnt = st.guard_cnt - 8'h01;
      end
      case (st.mode)
         DISABLED: begin
            // Sync character doubles as the enabling character
            if (sync_done && !sync_overflow && !sync_underflow) begin
               next_st.mode = WAIT_INSTR;
            end
         end
         WAIT_SYNC: begin
            if (sync_done) begin
               if (sync_overflow || sync_underflow) begin
                  next_st.mode = DISABLED;
               end else begin
                  next_st.mode = WAIT_INSTR;
               end
            end
         end
         WAIT_INSTR: begin
            if (rx_valid) begin
               next_st.op = rx_data[OP_POS +: 3];
               next_st.size_a = rx_data[SIZEA_POS +: 2];
               next_st.size_b = rx_data[SIZEB_POS +: 2];
               next_st.cnt = 3'h0;
               next_st.addr = 32'h0000_0000;
               next_st.guard_cnt = guard_bits(guard_time_field);
               next_st.mode = WAIT_SYNC;
               case (rx_data[OP_POS +: 3])
                  OP_LOAD_DIRECT, OP_STORE_DIRECT: begin
                     if (rx_data[SIZEA_POS +: 2] != ASIZE_RESERVED) begin
                        next_st.mode = ADDR_IN;
                     end
                  end
                  OP_LOAD_INDIRECT: begin
                     if (rx_data[SIZEA_POS +: 2] == PTR_REGISTER) begin
                        next_st.data = st.ptr;
                        next_st.cnt = byte_count(rx_data[SIZEB_POS +: 2]);
                        next_st.mode = TURN;
                     end else begin
                        next_st.addr = st.ptr;
                        next_st.bus_req = 1'b1;
                        next_st.bus_write = 1'b0;
                        next_st.timeout_cnt = 16'h0000;
                        next_st.mode = BUS_ACCESS;
                     end
                  end
                  OP_STORE_INDIRECT: begin
                     // Only the pointer-register form is served here
                     if (rx_data[SIZEA_POS +: 2] == PTR_REGISTER) begin
                        next_st.size_a = rx_data[SIZEB_POS +: 2];
                        next_st.mode = ADDR_IN;
                     end
                  end
                  default: next_st.mode = WAIT_SYNC;
               endcase
            end
         end
         ADDR_IN: begin
            if (rx_valid) begin
               next_st.addr = put_byte(st.addr, st.cnt, rx_data);
               next_st.cnt = st.cnt + 3'h1;
               if (st.cnt + 3'h1 == byte_count(st.size_a)) begin
                  next_st.guard_cnt = guard_bits(guard_time_field);
                  next_st.cnt = 3'h0;
                  if (st.op == OP_LOAD_DIRECT) begin
                     next_st.bus_req = 1'b1;
                     next_st.bus_write = 1'b0;
                     next_st.timeout_cnt = 16'h0000;
                     next_st.mode = BUS_ACCESS;
                  end else begin
                     if (st.op == OP_STORE_INDIRECT) begin
                        next_st.ptr = put_byte(st.addr, st.cnt, rx_data);
                        next_st.data_after_ack = 1'b0;
                     end else begin
                        next_st.data_after_ack = 1'b1;
                     end
                     next_st.data = {24'h000000, ACK_CHAR};
                     next_st.cnt = 3'h1;
                     next_st.mode = TURN;
                  end
               end
            end
         end
         DATA_IN: begin
            if (rx_valid) begin
               next_st.data = put_byte(st.data, st.cnt, rx_data);
               next_st.cnt = st.cnt + 3'h1;
               if (st.cnt + 3'h1 == byte_count(st.size_b)) begin
                  next_st.guard_cnt = guard_bits(guard_time_field);
                  next_st.bus_req = 1'b1;
                  next_st.bus_write = 1'b1;
                  next_st.timeout_cnt = 16'h0000;
                  next_st.mode = BUS_ACCESS;
               end
            end
         end
         BUS_ACCESS: begin
            next_st.timeout_cnt = st.timeout_cnt + 16'h0001;
            if (bus_done) begin
               next_st.bus_req = 1'b0;
               next_st.data_after_ack = 1'b0;
               if (st.bus_write) begin
                  next_st.data = {24'h000000, ACK_CHAR};
                  next_st.cnt = 3'h1;
               end else begin
                  next_st.data = bus_rdata;
                  next_st.cnt = byte_count(st.size_b);
                  if (st.op == OP_LOAD_INDIRECT && st.size_a == PTR_DEREF_INC) begin
                     next_st.ptr = st.ptr + {29'h0, byte_count(st.size_b)};
                  end
               end
               next_st.mode = TURN;
            end
         end
         TURN: begin
            // Guard runs during a slow bus access instead of adding to it
            if (st.guard_cnt == 8'h00) begin
               next_st.mode = TX_OUT;
            end
         end
         TX_OUT: begin
            if (tx_ready) begin
               next_st.data = st.data >> 8;
               next_st.cnt = st.cnt - 3'h1;
               if (st.cnt == 3'h1) begin
                  next_st.cnt = 3'h0;
                  next_st.mode = st.data_after_ack ? DATA_IN : WAIT_SYNC;
               end
            end
         end
         ERROR: begin
            if (rx_break) begin
               next_st.mode = WAIT_SYNC;
            end
         end
         default: next_st.mode = DISABLED;
      endcase
      // Errors outrank normal progress in every enabled state except ERROR
      if (st.mode != DISABLED && st.mode != ERROR) begin
         if (rx_break) begin
            next_st.mode = WAIT_SYNC;
            next_st.bus_req = 1'b0;
         end else if (rx_parity_err || rx_frame_err || tx_contention
                      || (st.mode == BUS_ACCESS && !bus_done
                          && st.timeout_cnt == TIMEOUT_LIMIT)) begin
            next_st.mode = ERROR;
            next_st.bus_req = 1'b0;
            if (rx_parity_err) begin
               next_st.err_sig = ERR_PARITY;
            end else if (rx_frame_err) begin
               next_st.err_sig = ERR_FRAME;
            end else if (tx_contention) begin
               next_st.err_sig = ERR_CONTENTION;
            end else begin
               next_st.err_sig = ERR_TIMEOUT;
            end
         end
      end
      if (iface_disable_bit && st.mode != DISABLED) begin
         next_st = '0;
         next_st.mode = DISABLED;
         next_st.ptr = PTR_RESET;
         next_st.sys_reset = 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         st <= '0;
         st.mode <= DISABLED;
      end else begin
         st <= next_st;
      end
   end
   assign tx_valid = (st.mode == TX_OUT);
   assign tx_data = st.data[7:0];
   assign error_signature_field = st.err_sig;
   assign iface_enabled = (st.mode != DISABLED);
   assign clk_request = (st.mode != DISABLED);
   assign sys_reset = st.sys_reset;
   assign cpu_run_req = st.sys_reset;
   assign bus_req = st.bus_req;
   assign bus_write = st.bus_write;
   assign bus_addr = st.addr;
   assign bus_wdata = st.data;
   assign bus_size = st.size_b;
   assign pointer = st.ptr;
   sequence s_bad_sync;
      st.mode == WAIT_SYNC && sync_done && (sync_overflow || sync_underflow)
         && !iface_disable_bit;
   endsequence
   property p_bad_sync;
      @(posedge clock) disable iff (reset) s_bad_sync |=> st.mode == DISABLED;
   endproperty
   a_bad_sync: assert property (p_bad_sync) else $error("bad sync kept link alive");
   property p_disable;
      @(posedge clock) disable iff (reset)
         (iface_disable_bit && iface_enabled) |=> (sys_reset && !iface_enabled) ##1 !sys_reset;
   endproperty
   a_disable: assert property (p_disable) else $error("disable gave no reset pulse");
   property p_clk_drop;
      @(posedge clock) disable iff (reset) $rose(sys_reset) |-> !clk_request && cpu_run_req;
   endproperty
   a_clk_drop: assert property (p_clk_drop) else $error("clock request kept at disable");
   property p_parity_code;
      @(posedge clock) disable iff (reset)
         (rx_parity_err && !rx_break && !iface_disable_bit && iface_enabled && st.mode != ERROR)
         |=> st.mode == ERROR && error_signature_field == ERR_PARITY;
   endproperty
   a_parity_code: assert property (p_parity_code) else $error("parity not recorded");
   property p_error_enter;
      @(posedge clock) disable iff (reset)
         (tx_contention && !rx_break && !iface_disable_bit && iface_enabled) |=> st.mode == ERROR;
   endproperty
   a_error_enter: assert property (p_error_enter) else $error("error state not entered");
   property p_error_quiet;
      @(posedge clock) disable iff (reset)
         (st.mode == ERROR && !rx_break && !iface_disable_bit) |=> !bus_req && !tx_valid;
   endproperty
   a_error_quiet: assert property (p_error_quiet) else $error("activity in error state");
   property p_guard_first;
      @(posedge clock) disable iff (reset) $rose(tx_valid) |-> $past(st.guard_cnt) == 8'h00;
   endproperty
   a_guard_first: assert property (p_guard_first) else $error("early response");
   property p_timeout;
      @(posedge clock) disable iff (reset)
         (st.mode == BUS_ACCESS && st.timeout_cnt == TIMEOUT_LIMIT && !bus_done && !rx_break
          && !rx_parity_err && !rx_frame_err && !tx_contention && !iface_disable_bit)
         |=> !bus_req && error_signature_field == ERR_TIMEOUT;
   endproperty
   a_timeout: assert property (p_timeout) else $error("access time-out not flagged");
   property p_no_increment;
      @(posedge clock) disable iff (reset)
         (st.mode == BUS_ACCESS && st.op == OP_LOAD_DIRECT && !iface_disable_bit)
         |=> $stable(pointer);
   endproperty
   a_no_increment: assert property (p_no_increment) else $error("pointer moved");
endmodule

// file: bus_access_model.sv
/*
 Behavioural bus-access layer standing behind the debug link controller.
 Assumes the controller holds bus_req high until the cycle after bus_done.
*/
module bus_access_model #(
   parameter logic [31:0] DATA_MASK = 32'h5A5A_C3C3
) (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        bus_req,
   input  wire logic        bus_write,
   input  wire logic [31:0] bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic [7:0]  delay,
   input  wire logic        hang,
   output logic             bus_done,
   output logic [31:0]      bus_rdata,
   output logic [31:0]      last_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] wait_cnt;
   logic       served;

   always @(posedge clock) begin
      if (reset) begin
         bus_done <= 1'b0;
         bus_rdata <= 32'h0;
         last_wdata <= 32'h0;
         wait_cnt <= 8'h0;
         served <= 1'b0;
      end else if (!bus_req) begin
         bus_done <= 1'b0;
         // Stale read data is inverted every cycle outside the done pulse
         bus_rdata <= ~bus_rdata;
         wait_cnt <= 8'h0;
         served <= 1'b0;
      end else if (!served && !hang && wait_cnt >= delay) begin
         bus_done <= 1'b1;
         bus_rdata <= bus_addr ^ DATA_MASK;
         if (bus_write) begin
            last_wdata <= bus_wdata;
         end
         served <= 1'b1;
      end else begin
         bus_done <= 1'b0;
         bus_rdata <= ~bus_rdata;
         if (!served && !hang) begin
            wait_cnt <= wait_cnt + 8'h1;
         end
      end
   end
endmodule

// file: one_wire_debug_link_ctrl_tb_top.sv
/*
 Self-checking bench of the debug link controller: byte-level line stimulus,
 bus-access partner model, error, disable and guard-time scenarios.
 Assumes the design package and the bus_access_model module are compiled first.
*/
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module one_wire_debug_link_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import one_wire_debug_link_pkg::*;
   localparam logic [31:0] MASK = 32'h5A5A_C3C3;
   logic        clock, reset, sync_overflow, sync_underflow, bit_tick, tx_ready, hang;
   logic        tx_valid, bus_req, bus_write, bus_done, iface_enabled, clk_request;
   logic        sys_reset, cpu_run_req;
   logic [6:0]  ev;
   logic [7:0]  rx_data, tx_data, delay;
   logic [2:0]  g, error_signature_field;
   logic [1:0]  bus_size, div;
   logic [31:0] bus_addr, bus_wdata, bus_rdata, pointer, last_wdata;
   int          ticks, gap, n_fail, checks, k, i;
   logic [6:0]  emask [3] = '{7'h04, 7'h08, 7'h20};
   logic [2:0]  ecode [3] = '{ERR_PARITY, ERR_FRAME, ERR_CONTENTION};

   one_wire_debug_link_ctrl dut_u (.clock(clock), .reset(reset), .sync_done(ev[0]),
      .sync_overflow(sync_overflow), .sync_underflow(sync_underflow), .rx_valid(ev[1]),
      .rx_data(rx_data), .rx_parity_err(ev[2]), .rx_frame_err(ev[3]), .rx_break(ev[4]),
      .tx_contention(ev[5]), .bit_tick(bit_tick), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .guard_time_field(g), .iface_disable_bit(ev[6]),
      .error_signature_field(error_signature_field), .iface_enabled(iface_enabled),
      .clk_request(clk_request), .sys_reset(sys_reset), .cpu_run_req(cpu_run_req),
      .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_done(bus_done),
      .bus_rdata(bus_rdata), .pointer(pointer));
   bus_access_model #(.DATA_MASK(MASK)) bus_u (.clock(clock), .reset(reset),
      .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .delay(delay), .hang(hang), .bus_done(bus_done),
      .bus_rdata(bus_rdata), .last_wdata(last_wdata));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Baud tick every four clocks; gap and tick counts restart on each rx byte
   always @(posedge clock) begin
      div <= div + 2'h1;
      bit_tick <= (div == 2'h3);
      gap <= ev[1] ? 0 : gap + 1;
      if (ev[1]) ticks <= 0;
      else if (bit_tick) ticks <= ticks + 1;
   end
   initial begin
      repeat (30000) @(posedge clock);
      n_fail++;
      test_done();
   end

   task test_done();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task fire(input logic [6:0] m);
      @(posedge clock);
      ev <= m;
      @(posedge clock);
      ev <= 7'h00;
   endtask
   task put(input logic [7:0] b);
      rx_data <= b;
      fire(7'h02);
   endtask
   task automatic wait_hi(input bit tx, input int lim);
      int  n;
      bit  ok;
      ok = 0;
      for (n = 0; n < lim && !ok; n++) begin
         @(posedge clock);
         #1;
         ok = tx ? (tx_valid === 1'b1) : (bus_req === 1'b1);
      end
      `CHK(ok, 1'b1)
   endtask
   task automatic quiet();
      int  n;
      bit  seen;
      seen = 0;
      for (n = 0; n < 30; n++) begin
         @(posedge clock);
         #1;
         seen |= (bus_req === 1'b1) || (tx_valid === 1'b1);
      end
      `CHK(seen, 1'b0)
   endtask
   task recv(input logic [7:0] exp, input bit first);
      wait_hi(1, 1200);
      if (first) begin
         `CHK(ticks >= (128 >> g), 1'b1)
         `CHK(gap <= ACCESS_TIMEOUT_CYCLES, 1'b1)
      end
      `CHK(tx_data, exp)
      @(posedge clock);
      tx_ready <= 1'b1;
      @(posedge clock);
      tx_ready <= 1'b0;
   endtask
   task automatic load_seq(input logic [7:0] ins, input logic [31:0] a, input int na,
                           input int nb, input logic [31:0] ea);
      logic [31:0] w;
      int          n;
      w = ea ^ MASK;
      fire(7'h01);
      put(ins);
      for (n = 0; n < na; n++) put(a[8*n +: 8]);
      wait_hi(0, 300);
      `CHK(bus_addr, ea)
      `CHK(bus_write, 1'b0)
      `CHK(bus_size, 2'(nb - 1))
      for (n = 0; n < nb; n++) recv(w[8*n +: 8], n == 0);
   endtask

   initial begin
      reset = 1'b1;
      {ev, sync_overflow, sync_underflow, tx_ready, hang, rx_data} = '0;
      {div, bit_tick, ticks, gap, n_fail, checks} = '0;
      g = 3'h7;
      delay = 8'h02;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1;
      `CHK(iface_enabled, 1'b0)
      `CHK(bus_req, 1'b0)
      load_seq(8'h05, 32'h1234, 2, 2, 32'h1234);
      g <= 3'h5;
      #1;
      `CHK(clk_request, 1'b1)
      load_seq(8'h05, 32'h1234, 2, 2, 32'h1234);
      delay <= 8'd40;
      load_seq(8'h0B, 32'h012345, 3, 4, 32'h012345);
      $display("test direct loads done");
      for (k = 0; k < 2; k++) begin
         sync_overflow <= (k == 0);
         sync_underflow <= (k == 1);
         fire(7'h01);
         {sync_overflow, sync_underflow} <= 2'b00;
         @(posedge clock);
         #1;
         `CHK(iface_enabled, 1'b0)
         load_seq(8'h00, 32'h21, 1, 1, 32'h21);
      end
      $display("test bad sync done");
      fire(7'h01);
      put(8'h40);
      put(8'h7E);
      recv(ACK_CHAR, 1);
      put(8'hC9);
      wait_hi(0, 300);
      `CHK(bus_write, 1'b1)
      `CHK(bus_addr, 32'h7E)
      `CHK(bus_wdata[7:0], 8'hC9)
      recv(ACK_CHAR, 0);
      `CHK(last_wdata[7:0], 8'hC9)
      $display("test direct store done");
      fire(7'h01);
      put(8'h6B);
      for (i = 0; i < 4; i++) put(8'(32'h2000 >> (8 * i)));
      recv(ACK_CHAR, 1);
      `CHK(pointer, 32'h2000)
      load_seq(8'h25, 32'h0, 0, 2, 32'h2000);
      @(posedge clock);
      #1;
      `CHK(pointer, 32'h2002)
      fire(7'h01);
      put(8'h29);
      recv(8'h02, 1);
      recv(8'h20, 0);
      $display("test indirect load done");
      fire(7'h01);
      put(8'h0C);
      put(8'h11);
      quiet();
      $display("test reserved size done");
      for (k = 0; k < 3; k++) begin
         fire(7'h01);
         fire(emask[k]);
         @(posedge clock);
         #1;
         `CHK(error_signature_field, ecode[k])
         put(8'h00);
         put(8'h33);
         quiet();
         fire(7'h10);
         load_seq(8'h00, 32'h33, 1, 1, 32'h33);
      end
      $display("test line errors done");
      hang <= 1'b1;
      fire(7'h01);
      put(8'h00);
      put(8'h44);
      wait_hi(0, 300);
      for (i = 0; i < 1100 && error_signature_field !== ERR_TIMEOUT; i++) begin
         @(posedge clock);
         #1;
      end
      `CHK(error_signature_field, ERR_TIMEOUT)
      `CHK(i > 990 && i < 1010, 1'b1)
      @(posedge clock);
      #1;
      `CHK(bus_req, 1'b0)
      hang <= 1'b0;
      fire(7'h40);
      #1;
      `CHK(sys_reset, 1'b1)
      `CHK(cpu_run_req, 1'b1)
      `CHK(iface_enabled, 1'b0)
      `CHK(clk_request, 1'b0)
      `CHK(error_signature_field, ERR_NONE)
      `CHK(pointer, PTR_RESET)
      @(posedge clock);
      #1;
      `CHK(sys_reset, 1'b0)
      $display("test timeout and disable done");
      test_done();
   end
endmodule
